// ### rtl/pot_i2c_slave.sv
// Purpose: Serial slave engine that reads and writes the wiper
// Assumes: Bus clock at most 400 kHz, sys_clk 250 MHz
// Notes: Open-drain data output; clock is never driven
`timescale 1ns/1ps
`default_nettype none
module pot_i2c_slave (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  output logic [6:0] wiper,
  output logic busy
);
  pin_if pins ();
  pot_pkg::slave_state_e state_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic is_read_r;
  logic sda_drive_r;
  logic wr_en;
  logic [6:0] wr_data;

  // ----------------------------------------------------------
  // Pin conditioning and wiper storage
  // ----------------------------------------------------------
  pin_filter u_filt (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .pins(pins)
  );

  wiper_reg #(.width(pot_pkg::wiper_width)) u_wiper (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .wr_en(wr_en),
    .wr_data(wr_data),
    .rd_data(wiper)
  );

  // Address match: fixed, no straps, general call is just a mismatch
  function automatic logic addr_hit(input logic [7:0] ctrl);
    addr_hit = (ctrl[7:1] == pot_pkg::slave_addr);
  endfunction

  // ----------------------------------------------------------
  // Serial state machine
  // ----------------------------------------------------------
  // Start always restarts address capture; stop always idles
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= pot_pkg::st_idle;
    end else if (clk_en) begin
      if (pins.start_seen) begin
        state_r <= pot_pkg::st_addr;
      end else if (pins.stop_seen) begin
        state_r <= pot_pkg::st_idle;
      end else if (pins.scl_fall) begin
        case (state_r)
          pot_pkg::st_addr: begin
            if (bit_cnt_r == pot_pkg::bits_per_byte) begin
              // Mismatch falls off the bus until a new start
              state_r <= addr_hit(shift_r) ? pot_pkg::st_addr_ack : pot_pkg::st_idle;
            end
          end
          pot_pkg::st_addr_ack: begin
            state_r <= is_read_r ? pot_pkg::st_rd_data : pot_pkg::st_wr_data;
          end
          pot_pkg::st_wr_data: begin
            if (bit_cnt_r == pot_pkg::bits_per_byte) state_r <= pot_pkg::st_wr_ack;
          end
          pot_pkg::st_wr_ack: begin
            state_r <= pot_pkg::st_wr_data;
          end
          pot_pkg::st_rd_data: begin
            if (bit_cnt_r == pot_pkg::bits_per_byte) state_r <= pot_pkg::st_rd_ack;
          end
          pot_pkg::st_rd_ack: begin
            // Nack from the master ends the read
            state_r <= shift_r[0] ? pot_pkg::st_idle : pot_pkg::st_rd_data;
          end
          default: begin
            state_r <= state_r;
          end
        endcase
      end
    end
  end

  // Bit counter counts sampled bits; cleared at each byte boundary
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (pins.start_seen || pins.stop_seen) begin
        bit_cnt_r <= 4'h0;
      end else if (pins.scl_fall && (bit_cnt_r == pot_pkg::bits_per_byte)) begin
        bit_cnt_r <= 4'h0;
      end else if (pins.scl_rise && (state_r == pot_pkg::st_addr || state_r == pot_pkg::st_wr_data ||
                                     state_r == pot_pkg::st_rd_data)) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Shift register samples data on clock rise; ack slot samples the master
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      shift_r <= 8'h00;
    end else if (clk_en && pins.scl_rise) begin
      shift_r <= {shift_r[6:0], pins.sda_level};
    end
  end

  // Direction latched from the eighth control bit
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      is_read_r <= 1'b0;
    end else if (clk_en && pins.scl_fall && state_r == pot_pkg::st_addr &&
                 bit_cnt_r == pot_pkg::bits_per_byte) begin
      is_read_r <= shift_r[0];
    end
  end

  // Commit on the falling edge that opens the ack slot, so a stop or
  // start before that edge discards the byte
  assign wr_en = pins.scl_fall && !pins.start_seen && !pins.stop_seen &&
                 state_r == pot_pkg::st_wr_data && bit_cnt_r == pot_pkg::bits_per_byte;
  assign wr_data = shift_r[6:0];

  // ----------------------------------------------------------
  // Data line drive, changed only while the clock is low
  // ----------------------------------------------------------
  logic [7:0] tx_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sda_drive_r <= 1'b0;
      tx_r <= 8'h00;
    end else if (clk_en) begin
      if (pins.start_seen || pins.stop_seen) begin
        sda_drive_r <= 1'b0;
      end else if (pins.scl_fall) begin
        case (state_r)
          pot_pkg::st_addr: begin
            // Ack only a matching control byte
            sda_drive_r <= (bit_cnt_r == pot_pkg::bits_per_byte) && addr_hit(shift_r);
          end
          pot_pkg::st_addr_ack: begin
            if (is_read_r) begin
              tx_r <= {1'b0, wiper};
              sda_drive_r <= 1'b1; // Top bit of the read byte is always zero, so drive low
            end else begin
              sda_drive_r <= 1'b0;
            end
          end
          pot_pkg::st_wr_data: begin
            sda_drive_r <= (bit_cnt_r == pot_pkg::bits_per_byte);
          end
          pot_pkg::st_wr_ack: begin
            sda_drive_r <= 1'b0;
          end
          pot_pkg::st_rd_data: begin
            if (bit_cnt_r == pot_pkg::bits_per_byte) begin
              sda_drive_r <= 1'b0; // Release for master ack
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_drive_r <= ~tx_r[6];
            end
          end
          pot_pkg::st_rd_ack: begin
            // Next byte on master ack, release on nack
            tx_r <= {1'b0, wiper};
            sda_drive_r <= ~shift_r[0];
          end
          default: begin
            sda_drive_r <= 1'b0;
          end
        endcase
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = sda_drive_r;
  // Clock never stretched
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;
  assign busy = (state_r != pot_pkg::st_idle);
endmodule // pot_i2c_slave
`default_nettype wire

// ### include/pot_pkg.sv
// Purpose: Shared constants for the potentiometer serial slave
// Assumes: sys_clk at 250 MHz, bus clock far slower
// Notes: Summary of operation listed below
//
// Summary of operation
// - Slave only, seven-bit fixed address
// - Match address 0101111, eighth bit selects direction
// - No address straps; all instances share address
// - Control byte only first after start
// - General call ignored, never acknowledged
// - Software reset clears serial engine only
// - Start while receiving restarts the engine
// - Master nack after read byte resets engine
// - After stop stay idle until start
// - Write when direction bit zero; acknowledge bytes
// - Write byte committed during its acknowledge
// - Partial byte before stop or start discarded
// - Any number of write bytes until stop
// - Written byte top bit ignored, seven stored
// - Read when direction bit one; send bytes
// - Hold data line for eight bits, then release
// - Mismatched address left unacknowledged
// - Clock line never held low
// - Invalid sequence: release line, wait for start
// - Reset loads wiper with mid-scale 3Fh
package pot_pkg;
  localparam logic [6:0] slave_addr = 7'h2f;
  localparam logic [6:0] wiper_reset = 7'h3f;
  localparam int wiper_width = 7;
  localparam int sync_stages = 3;
  localparam logic [3:0] bits_per_byte = 4'h8;
  typedef enum logic [2:0] {st_idle, st_addr, st_addr_ack, st_wr_data, st_wr_ack, st_rd_data, st_rd_ack} slave_state_e;
endpackage

// ### include/pin_if.sv
// Purpose: Carries cleaned bus line levels and line events
// Assumes: Driven by the pin filter, read by the top
// Notes: Events are one-cycle pulses in the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
interface pin_if;
  logic scl_level;
  logic sda_level;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  modport filt (output scl_level, output sda_level, output scl_rise, output scl_fall, output start_seen,
    output stop_seen);
  modport eng (input scl_level, input sda_level, input scl_rise, input scl_fall, input start_seen,
    input stop_seen);
endinterface
`default_nettype wire

// ### rtl/pin_filter.sv
// Purpose: Synchronise clock and data pins and find bus events
// Assumes: Pins asynchronous to sys_clk
// Notes: A level changes only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_filter (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  pin_if.filt pins
);
  logic [pot_pkg::sync_stages-1:0] scl_sync_r;
  logic [pot_pkg::sync_stages-1:0] sda_sync_r;
  logic scl_r;
  logic sda_r;
  // ----------------------------------------------------------
  // Synchronisers, idle high like the pulled-up bus
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
    end else if (clk_en) begin
      scl_sync_r <= {scl_sync_r[1:0], scl_in};
      sda_sync_r <= {sda_sync_r[1:0], sda_in};
    end
  end
  // Filtered level follows only when the last two stages agree
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else if (clk_en) begin
      if (scl_sync_r[1] == scl_sync_r[2]) scl_r <= scl_sync_r[2];
      if (sda_sync_r[1] == sda_sync_r[2]) sda_r <= sda_sync_r[2];
    end
  end
  // Start is data falling, stop is data rising, with clock high
  wire logic scl_new = (scl_sync_r[1] == scl_sync_r[2]) ? scl_sync_r[2] : scl_r;
  wire logic sda_new = (sda_sync_r[1] == sda_sync_r[2]) ? sda_sync_r[2] : sda_r;
  assign pins.scl_level = scl_r;
  assign pins.sda_level = sda_r;
  assign pins.scl_rise = clk_en & scl_new & ~scl_r;
  assign pins.scl_fall = clk_en & ~scl_new & scl_r;
  assign pins.start_seen = clk_en & scl_r & scl_new & sda_r & ~sda_new;
  assign pins.stop_seen = clk_en & scl_r & scl_new & ~sda_r & sda_new;
endmodule // pin_filter
`default_nettype wire

// ### rtl/wiper_reg.sv
// Purpose: Seven-bit volatile wiper setting
// Assumes: Written only from the serial engine
// Notes: Read data come straight from the register
`timescale 1ns/1ps
`default_nettype none
module wiper_reg #(
  parameter int width = pot_pkg::wiper_width
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [width-1:0] wr_data,
  output logic [width-1:0] rd_data
);
  // Only the seven-bit wiper is served; any other width stops elaboration
  if (width != pot_pkg::wiper_width) begin : g_bad_width
    $error("wiper width must be 7");
  end
  // Power-on loads mid-scale; serial resets never touch it
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= pot_pkg::wiper_reset;
    end else if (clk_en && wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule // wiper_reg
`default_nettype wire

// ### bench/pot_asserts.sv
// Purpose: Port checks for the wiper serial slave
// Assumes: Pull-ups on both bus lines
// Notes: Paused while reset or clock enable is low
`timescale 1ns/1ps
`default_nettype none
module pot_asserts (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic [6:0] wiper,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || !clk_en);
  // Bus conditions seen on the raw pins, before the design's filter
  sequence start_c;
    scl_in && $fell(sda_in);
  endsequence
  sequence stop_c;
    scl_in && $rose(sda_in);
  endsequence
  a_scl_never_held: assert property (!scl_oe && !scl_out) else $error("clock line driven");
  a_idle_released: assert property (!busy |-> !sda_oe) else $error("data driven while idle");
  a_stop_to_idle: assert property (stop_c |-> ##[1:8] !busy) else $error("no idle after stop");
  a_start_engages: assert property (start_c |-> ##[1:8] busy) else $error("start not taken");
  a_wiper_at_ack: assert property ($changed(wiper) |-> busy && !scl_in) else $error("wiper moved off slot");
  a_data_steady: assert property ($changed(sda_oe) |-> !scl_in) else $error("data moved with clock high");
  a_drive_whole: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("data drive too short");
  a_reset_mid: assert property ($rose(nrst) |-> wiper == pot_pkg::wiper_reset) else $error("wiper not mid");
endmodule // pot_asserts
bind pot_i2c_slave pot_asserts chk_u (.sys_clk, .nrst, .clk_en, .scl_in, .sda_in, .sda_out, .sda_oe, .scl_out,
  .scl_oe, .wiper, .busy);
`default_nettype wire

// ### bench/i2c_master_model.sv
// Purpose: Bus master that clocks the slave at a 48 ns period
// Assumes: Lines are open drain with pull-ups
// Notes: Edges move just after a sys_clk edge
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input wire logic sys_clk,
  input wire logic sda_lvl,
  output logic scl_pull,
  output logic sda_pull
);
  // Both lines released at power-up
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // One quarter of the bus period, three system cycles
  task automatic quarter;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // One bit; a 1 releases data so the slave may pull it
  task automatic bit_x(input logic b, output logic r);
    sda_pull = !b;
    quarter();
    scl_pull = 1'b0;
    quarter();
    r = sda_lvl;
    quarter();
    scl_pull = 1'b1;
    quarter();
  endtask
  // Start or repeated start ahead of every control byte
  task automatic start;
    scl_pull = 1'b1;
    quarter();
    sda_pull = 1'b0;
    quarter();
    scl_pull = 1'b0;
    quarter();
    sda_pull = 1'b1;
    quarter();
    scl_pull = 1'b1;
    // Hold data after the clock falls so the first bit cannot mimic a stop
    quarter();
  endtask
  // Stop always closes a command, also a single write or read
  task automatic stop;
    scl_pull = 1'b1;
    quarter();
    sda_pull = 1'b1;
    quarter();
    scl_pull = 1'b0;
    quarter();
    sda_pull = 1'b0;
    quarter();
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, ack);
  endtask
  // Master acknowledges all bytes but the last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(last, r);
  endtask
  // Recovery: start, nine released bits, start, stop
  task automatic recover;
    logic r;
    start();
    repeat (9) bit_x(1'b1, r);
    start();
    stop();
  endtask
endmodule // i2c_master_model
`default_nettype wire

// ### bench/pot_wiper_i2c_slave_tb.sv
// Purpose: Self-checking bench for the wiper serial slave
// Assumes: Master model clocks the bus
// Notes: Wiper values chained across scenarios
`timescale 1ns/1ps
`default_nettype none
module pot_wiper_i2c_slave_tb;
  logic sys_clk, nrst, clk_en, scl_pull, sda_pull, sda_out, sda_oe, scl_out, scl_oe, busy, ack;
  logic [6:0] wiper;
  logic [7:0] d;
  logic [7:0] bad_addr [3] = '{8'h00, 8'h5c, 8'h5b};
  int bad_count = 0;
  int comparisons = 0;
  // Pulled-up wires: low while any party pulls; a driven pad only ever pulls low
  wire logic scl = !scl_pull && !(scl_oe && !scl_out);
  wire logic sda = !sda_pull && !(sda_oe && !sda_out);
  pot_i2c_slave dut_u (.sys_clk, .nrst, .clk_en, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe, .scl_out,
    .scl_oe, .wiper, .busy);
  i2c_master_model m_u (.sys_clk, .sda_lvl(sda), .scl_pull, .sda_pull);
  // 250 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Bounded wait for the engine to go idle
  task automatic idle_chk;
    for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  task automatic s_write;
    m_u.start();
    m_u.wr_byte(8'h5e, ack);
    chk("ctl ack", 8'h00, {7'h0, ack});
    m_u.wr_byte(8'hc5, ack);
    chk("wiper", 8'h45, {1'b0, wiper});
    chk("data ack", 8'h00, {7'h0, ack});
    m_u.wr_byte(8'h12, ack);
    chk("wiper", 8'h12, {1'b0, wiper});
    chk("data ack", 8'h00, {7'h0, ack});
    m_u.stop();
    idle_chk();
  endtask
  task automatic s_read;
    m_u.start();
    m_u.wr_byte(8'h5f, ack);
    chk("rd ack", 8'h00, {7'h0, ack});
    m_u.rd_byte(1'b0, d);
    chk("rd byte", 8'h12, d);
    m_u.rd_byte(1'b1, d);
    chk("rd last", 8'h12, d);
    idle_chk();
    chk("sda out", 8'h00, {7'h0, sda_out});
    chk("scl oe", 8'h00, {7'h0, scl_oe});
    m_u.stop();
  endtask
  // Foreign addresses, general call first, stay unanswered
  task automatic s_bad;
    foreach (bad_addr[i]) begin
      m_u.start();
      m_u.wr_byte(bad_addr[i], ack);
      chk("bad ack", 8'h01, {7'h0, ack});
      m_u.wr_byte(8'h06, ack);
      chk("cmd ack", 8'h01, {7'h0, ack});
      m_u.stop();
      chk("wiper", 8'h12, {1'b0, wiper});
    end
  endtask
  // Half bytes cut by repeated start and by stop
  task automatic s_partial;
    m_u.start();
    m_u.wr_byte(8'h5e, ack);
    repeat (4) m_u.bit_x(1'b0, ack);
    m_u.start();
    m_u.wr_byte(8'h5e, ack);
    chk("rs ack", 8'h00, {7'h0, ack});
    repeat (4) m_u.bit_x(1'b0, ack);
    m_u.stop();
    chk("wiper", 8'h12, {1'b0, wiper});
  endtask
  task automatic s_recover;
    m_u.start();
    m_u.wr_byte(8'h5f, ack);
    m_u.recover();
    idle_chk();
    chk("wiper", 8'h12, {1'b0, wiper});
  endtask
  // Mid-run reset brings mid-scale back, and a single read returns it
  task automatic s_reset;
    nrst = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk("rst wiper", 8'h3f, {1'b0, wiper});
    chk("rst busy", 8'h00, {7'h0, busy});
    nrst = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    m_u.start();
    m_u.wr_byte(8'h5f, ack);
    chk("rst rd ack", 8'h00, {7'h0, ack});
    m_u.rd_byte(1'b1, d);
    chk("rst rd byte", 8'h3f, d);
    m_u.stop();
    idle_chk();
  endtask
  // Hang guard
  initial begin
    repeat (50000) @(posedge sys_clk);
    bad_count++;
    end_sim();
  end
  initial begin
    nrst = 1'b0;
    clk_en = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    clk_en = 1'b1;
    // Let the engine see released lines before the first start
    repeat (2) @(posedge sys_clk);
    #1;
    chk("reset wiper", 8'h3f, {1'b0, wiper});
    s_write();
    s_read();
    s_bad();
    s_partial();
    s_recover();
    s_reset();
    end_sim();
  end
endmodule // pot_wiper_i2c_slave_tb
`default_nettype wire
